//--- rtl/aux_output_sequencer_config.sv
// auxiliary output sequencer with its delay, control and config registers
// assumes enable_pin and shared_pin_in are asynchronous pins; register port is
// driven by the serial interface logic on clk, one access per strobe
//
// Notes on behaviour
// - output a goes low its fall code times step after enable falls; zero immediate
// - output a goes high its rise code times step after enable rises; code resets 7
// - output b goes low its fall code times step after enable falls; code resets 2
// - output b goes high its rise code times step after enable rises; code resets 2
// - rise range bit picks 0.5 ms or 1 ms steps for all rise codes
// - fall range bit picks 0.5 ms or 1 ms steps for all fall codes
// - output a follows its level bit, or level and sequenced enable when gated
// - output b follows its level bit, or level and sequenced enable when gated
// - output a level bit: zero low, one high; resets to one
// - output b level bit: zero low, one high; only while shared pin is output
// - output a drive type: zero push-pull, one open-drain releasing for high
// - output b drive type: zero push-pull, one open-drain, while pin is output
// - pin function bit: zero output b, one external clock input; resets zero
// - shared pin pull-down bit enables pull-down in either pin function
// - enable pin pull-down bit enables its pull-down; resets to one
// - thermal warning bit selects 125 or 137 degree threshold; resets to one
// - spread clock bit turns spread spectrum off or on; resets to zero
module aux_output_sequencer_config #(
   parameter int unsigned STEP_CYCLES = aux_seq_pkg::STEP_CYCLES
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   enable_pin,
   input  wire aux_seq_pkg::reg_addr_t reg_addr,
   input  wire logic                   reg_wr,
   input  wire aux_seq_pkg::reg_data_t reg_wdata,
   input  wire logic                   reg_rd,
   output aux_seq_pkg::reg_data_t      reg_rdata_r,
   output logic                        aux_a_out_r,
   output logic                        aux_a_oe_n_r,
   input  wire logic                   shared_pin_in,
   output logic                        aux_b_out_r,
   output logic                        aux_b_oe_n_r,
   output logic                        ext_clock_input_r,
   output logic                        shared_pin_pulldown_r,
   output logic                        enable_pin_pulldown_r,
   output logic                        thermal_warning_threshold_r,
   output logic                        spread_clock_enable_r
);
   import aux_seq_pkg::*;

   localparam int STEP_W = $clog2(STEP_CYCLES + 1);

   reg_data_t   aux_a_delay_r;
   reg_data_t   aux_b_delay_r;
   reg_data_t   aux_ctrl_r;
   reg_data_t   dev_config_r;
   logic        en_meta_r;
   logic        en_sync_r;
   logic        en_prev_r;
   logic        clk_meta_r;
   logic        clk_sync_r;
   logic        en_rise_p;
   logic        en_fall_p;
   logic [STEP_W-1:0] tick_cnt_r;
   logic        tick;
   logic        seq_a_r;
   logic        seq_b_r;
   logic        a_value;
   logic        b_value;
   logic        rise_long;
   logic        fall_long;

   assign rise_long = dev_config_r[CFG_RISE_RANGE];
   assign fall_long = dev_config_r[CFG_FALL_RANGE];

   // register writes; reserved control bits stay zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_a_delay_r <= RST_AUX_A_DELAY;
         aux_b_delay_r <= RST_AUX_B_DELAY;
         aux_ctrl_r    <= RST_AUX_CTRL;
         dev_config_r  <= RST_DEV_CONFIG;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_AUX_A_DELAY: aux_a_delay_r <= reg_wdata;
            ADDR_AUX_B_DELAY: aux_b_delay_r <= reg_wdata;
            ADDR_AUX_CTRL:    aux_ctrl_r    <= reg_wdata & CTRL_WRITE_MASK;
            ADDR_DEV_CONFIG:  dev_config_r  <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // read data held until the next read strobe; unmapped reads give zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ADDR_AUX_A_DELAY: reg_rdata_r <= aux_a_delay_r;
            ADDR_AUX_B_DELAY: reg_rdata_r <= aux_b_delay_r;
            ADDR_AUX_CTRL:    reg_rdata_r <= aux_ctrl_r;
            ADDR_DEV_CONFIG:  reg_rdata_r <= dev_config_r;
            default:          reg_rdata_r <= 8'h00;
         endcase
      end
   end

   // enable pin synchroniser and edge detect
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         en_meta_r <= 1'b0;
         en_sync_r <= 1'b0;
         en_prev_r <= 1'b0;
      end else begin
         en_meta_r <= enable_pin;
         en_sync_r <= en_meta_r;
         en_prev_r <= en_sync_r;
      end
   end

   assign en_rise_p = en_sync_r & ~en_prev_r;
   assign en_fall_p = ~en_sync_r & en_prev_r;

   // shared pin seen as clock input; only a level copy here, the pll lives elsewhere
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clk_meta_r        <= 1'b0;
         clk_sync_r        <= 1'b0;
         ext_clock_input_r <= 1'b0;
      end else begin
         clk_meta_r        <= shared_pin_in;
         clk_sync_r        <= clk_meta_r;
         ext_clock_input_r <= clk_sync_r & dev_config_r[CFG_PIN_FUNCTION];
      end
   end

   // step tick restarted at every edge so the first step is a full one
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tick_cnt_r <= '0;
      end else if (en_rise_p || en_fall_p || tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + STEP_W'(1);
      end
   end

   assign tick = (tick_cnt_r == STEP_W'(STEP_CYCLES - 1));

   // range bits scale every code of both channels
   aux_delay_channel u_chan_a (
      .clk       (clk),
      .reset     (reset),
      .tick      (tick),
      .rise_p    (en_rise_p),
      .fall_p    (en_fall_p),
      .rise_code (aux_a_delay_r[RISE_LSB+:4]),
      .fall_code (aux_a_delay_r[FALL_LSB+:4]),
      .rise_long (rise_long),
      .fall_long (fall_long),
      .active_r  (seq_a_r)
   );

   aux_delay_channel u_chan_b (
      .clk       (clk),
      .reset     (reset),
      .tick      (tick),
      .rise_p    (en_rise_p),
      .fall_p    (en_fall_p),
      .rise_code (aux_b_delay_r[RISE_LSB+:4]),
      .fall_code (aux_b_delay_r[FALL_LSB+:4]),
      .rise_long (rise_long),
      .fall_long (fall_long),
      .active_r  (seq_b_r)
   );

   // gating ands the level bit with the sequenced enable
   assign a_value = aux_ctrl_r[CTRL_A_LEVEL]
                    & (~aux_ctrl_r[CTRL_A_PIN_GATING] | seq_a_r);
   assign b_value = aux_ctrl_r[CTRL_B_LEVEL]
                    & (~aux_ctrl_r[CTRL_B_PIN_GATING] | seq_b_r);

   // open-drain only pulls low; high releases the pin
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_a_out_r  <= 1'b0;
         aux_a_oe_n_r <= 1'b1;
      end else if (aux_ctrl_r[CTRL_A_DRIVE_TYPE]) begin
         aux_a_out_r  <= 1'b0;
         aux_a_oe_n_r <= a_value;
      end else begin
         aux_a_out_r  <= a_value;
         aux_a_oe_n_r <= 1'b0;
      end
   end

   // clock-input function releases the pin whatever the drive bits say
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_b_out_r  <= 1'b0;
         aux_b_oe_n_r <= 1'b1;
      end else if (dev_config_r[CFG_PIN_FUNCTION]) begin
         aux_b_out_r  <= 1'b0;
         aux_b_oe_n_r <= 1'b1;
      end else if (aux_ctrl_r[CTRL_B_DRIVE_TYPE]) begin
         aux_b_out_r  <= 1'b0;
         aux_b_oe_n_r <= b_value;
      end else begin
         aux_b_out_r  <= b_value;
         aux_b_oe_n_r <= 1'b0;
      end
   end

   // static controls for the analog side
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         shared_pin_pulldown_r       <= RST_DEV_CONFIG[CFG_SHARED_PD];
         enable_pin_pulldown_r       <= RST_DEV_CONFIG[CFG_ENABLE_PD];
         thermal_warning_threshold_r <= RST_DEV_CONFIG[CFG_THERMAL_LEVEL];
         spread_clock_enable_r       <= RST_DEV_CONFIG[CFG_SPREAD_EN];
      end else begin
         shared_pin_pulldown_r       <= dev_config_r[CFG_SHARED_PD];
         enable_pin_pulldown_r       <= dev_config_r[CFG_ENABLE_PD];
         thermal_warning_threshold_r <= dev_config_r[CFG_THERMAL_LEVEL];
         spread_clock_enable_r       <= dev_config_r[CFG_SPREAD_EN];
      end
   end

   // checking helpers: cycles since last edge and the delay each channel owes
   int unsigned since_edge;
   int unsigned exp_a;
   int unsigned exp_b;
   logic        prev_a;
   logic        prev_b;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         since_edge <= 0;
         exp_a      <= 0;
         exp_b      <= 0;
         prev_a     <= 1'b0;
         prev_b     <= 1'b0;
      end else begin
         prev_a <= seq_a_r;
         prev_b <= seq_b_r;
         if (en_rise_p || en_fall_p) begin
            since_edge <= 0;
            exp_a <= STEP_CYCLES * (en_rise_p
                     ? code_steps(aux_a_delay_r[RISE_LSB+:4], rise_long)
                     : code_steps(aux_a_delay_r[FALL_LSB+:4], fall_long));
            exp_b <= STEP_CYCLES * (en_rise_p
                     ? code_steps(aux_b_delay_r[RISE_LSB+:4], rise_long)
                     : code_steps(aux_b_delay_r[FALL_LSB+:4], fall_long));
         end else begin
            since_edge <= since_edge + 1;
         end
      end
   end

   sequence s_cfg_write;
      reg_wr && reg_addr == ADDR_DEV_CONFIG;
   endsequence

   sequence s_pin_to_output;
      reg_wr && reg_addr == ADDR_DEV_CONFIG && !reg_wdata[CFG_PIN_FUNCTION];
   endsequence

   a_a_rise_time: assert property (@(posedge clk) disable iff (reset)
      (seq_a_r && !prev_a) |-> since_edge == exp_a && en_prev_r)
      else $error("output a rose at the wrong time");

   a_a_fall_time: assert property (@(posedge clk) disable iff (reset)
      (!seq_a_r && prev_a) |-> since_edge == exp_a && !en_prev_r)
      else $error("output a fell at the wrong time");

   a_b_rise_time: assert property (@(posedge clk) disable iff (reset)
      (seq_b_r && !prev_b) |-> since_edge == exp_b && en_prev_r)
      else $error("output b rose at the wrong time");

   a_b_fall_time: assert property (@(posedge clk) disable iff (reset)
      (!seq_b_r && prev_b) |-> since_edge == exp_b && !en_prev_r)
      else $error("output b fell at the wrong time");

   a_a_ungated_level: assert property (@(posedge clk) disable iff (reset)
      (!aux_ctrl_r[CTRL_A_PIN_GATING] && !aux_ctrl_r[CTRL_A_DRIVE_TYPE]) [*2]
      |-> aux_a_out_r == $past(aux_ctrl_r[CTRL_A_LEVEL]) && !aux_a_oe_n_r)
      else $error("ungated output a does not follow its level bit");

   a_a_open_drain: assert property (@(posedge clk) disable iff (reset)
      aux_ctrl_r[CTRL_A_DRIVE_TYPE] |=> !aux_a_out_r)
      else $error("open-drain output a drove high");

   a_b_gated_low: assert property (@(posedge clk) disable iff (reset)
      (aux_ctrl_r[CTRL_B_PIN_GATING] && !seq_b_r && !dev_config_r[CFG_PIN_FUNCTION])
      |=> !aux_b_out_r && (aux_b_oe_n_r == 1'b0))
      else $error("gated output b not low while sequence is off");

   a_b_clock_mode: assert property (@(posedge clk) disable iff (reset)
      dev_config_r[CFG_PIN_FUNCTION] |=> aux_b_oe_n_r && !aux_b_out_r)
      else $error("shared pin driven while set as clock input");

   a_cfg_outputs: assert property (@(posedge clk) disable iff (reset)
      s_cfg_write |-> ##2 shared_pin_pulldown_r == $past(reg_wdata[CFG_SHARED_PD], 2)
         && enable_pin_pulldown_r == $past(reg_wdata[CFG_ENABLE_PD], 2)
         && thermal_warning_threshold_r == $past(reg_wdata[CFG_THERMAL_LEVEL], 2)
         && spread_clock_enable_r == $past(reg_wdata[CFG_SPREAD_EN], 2))
      else $error("config outputs do not follow a config write");

   a_pin_back_out: assert property (@(posedge clk) disable iff (reset)
      s_pin_to_output ##1 !reg_wr |=> !dev_config_r[CFG_PIN_FUNCTION])
      else $error("pin function write not taken");

   a_edge_restarts: assert property (@(posedge clk) disable iff (reset)
      (en_rise_p || en_fall_p) |=> tick_cnt_r == '0)
      else $error("step tick not restarted on an enable edge");

   // ungated drive settings, held two cycles so the output flop reflects them
   sequence s_a_od_free;
      aux_ctrl_r[CTRL_A_DRIVE_TYPE] && !aux_ctrl_r[CTRL_A_PIN_GATING];
   endsequence

   sequence s_b_pp_free;
      !aux_ctrl_r[CTRL_B_DRIVE_TYPE] && !aux_ctrl_r[CTRL_B_PIN_GATING]
         && !dev_config_r[CFG_PIN_FUNCTION];
   endsequence

   a_a_gated_low: assert property (@(posedge clk) disable iff (reset)
      (aux_ctrl_r[CTRL_A_PIN_GATING] && !seq_a_r) |=> !aux_a_out_r && !aux_a_oe_n_r)
      else $error("gated output a not low while sequence is off");

   a_a_od_release: assert property (@(posedge clk) disable iff (reset)
      s_a_od_free ##1 s_a_od_free |-> aux_a_oe_n_r == $past(aux_ctrl_r[CTRL_A_LEVEL]))
      else $error("open-drain output a does not release for a high level");

   a_b_open_drain: assert property (@(posedge clk) disable iff (reset)
      aux_ctrl_r[CTRL_B_DRIVE_TYPE] |=> !aux_b_out_r)
      else $error("open-drain output b drove high");

   a_b_ungated_level: assert property (@(posedge clk) disable iff (reset)
      s_b_pp_free ##1 s_b_pp_free
      |-> aux_b_out_r == $past(aux_ctrl_r[CTRL_B_LEVEL]) && !aux_b_oe_n_r)
      else $error("ungated output b does not follow its level bit");

   a_clock_copy: assert property (@(posedge clk) disable iff (reset)
      !dev_config_r[CFG_PIN_FUNCTION] |=> !ext_clock_input_r)
      else $error("clock input copy active while pin is an output");

endmodule

//--- include/aux_seq_pkg.sv
// constants and types for the auxiliary output sequencer and its config register
// assumes a 250 MHz core clock and an 8-bit register port fed by the serial interface
package aux_seq_pkg;

   typedef logic [7:0] reg_addr_t;
   typedef logic [7:0] reg_data_t;
   typedef logic [3:0] delay_code_t;
   typedef logic [4:0] delay_steps_t;

   // clock and delay step
   localparam int unsigned CLK_PERIOD_NS  = 4;
   localparam int unsigned STEP_TIME_NS   = 500000;
   localparam int unsigned STEP_CYCLES    = STEP_TIME_NS / CLK_PERIOD_NS;

   // register offsets
   localparam reg_addr_t ADDR_AUX_A_DELAY = 8'h10;
   localparam reg_addr_t ADDR_AUX_B_DELAY = 8'h11;
   localparam reg_addr_t ADDR_AUX_CTRL    = 8'h12;
   localparam reg_addr_t ADDR_DEV_CONFIG  = 8'h13;

   // reset values
   localparam reg_data_t RST_AUX_A_DELAY  = 8'h07;
   localparam reg_data_t RST_AUX_B_DELAY  = 8'h22;
   localparam reg_data_t RST_AUX_CTRL     = 8'h77;
   localparam reg_data_t RST_DEV_CONFIG   = 8'h06;
   localparam reg_data_t CTRL_WRITE_MASK  = 8'h77;

   // delay register fields: fall code high nibble, rise code low nibble
   localparam int FALL_LSB = 4;
   localparam int RISE_LSB = 0;

   // aux_output_control fields
   localparam int CTRL_B_DRIVE_TYPE = 6;
   localparam int CTRL_B_PIN_GATING = 5;
   localparam int CTRL_B_LEVEL      = 4;
   localparam int CTRL_A_DRIVE_TYPE = 2;
   localparam int CTRL_A_PIN_GATING = 1;
   localparam int CTRL_A_LEVEL      = 0;

   // device_config fields
   localparam int CFG_RISE_RANGE    = 6;
   localparam int CFG_FALL_RANGE    = 5;
   localparam int CFG_PIN_FUNCTION  = 4;
   localparam int CFG_SHARED_PD     = 3;
   localparam int CFG_ENABLE_PD     = 2;
   localparam int CFG_THERMAL_LEVEL = 1;
   localparam int CFG_SPREAD_EN     = 0;

   // half-ms steps for a code; long range doubles each step to 1 ms
   function automatic delay_steps_t code_steps(input delay_code_t code, input logic long_range);
      code_steps = long_range ? {code, 1'b0} : {1'b0, code};
   endfunction

endpackage

//--- rtl/aux_delay_channel.sv
// one sequenced enable: delays each enable edge by a coded number of steps
// assumes edge pulses and tick come from the same clock, tick restarted at each edge
module aux_delay_channel (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic                      tick,
   input  wire logic                      rise_p,
   input  wire logic                      fall_p,
   input  wire aux_seq_pkg::delay_code_t  rise_code,
   input  wire aux_seq_pkg::delay_code_t  fall_code,
   input  wire logic                      rise_long,
   input  wire logic                      fall_long,
   output logic                           active_r
);
   import aux_seq_pkg::*;

   delay_steps_t remain_r;
   logic         target_r;
   logic         pending_r;
   delay_steps_t load_steps;

   always_comb begin
      load_steps = rise_p ? code_steps(rise_code, rise_long)
                          : code_steps(fall_code, fall_long);
   end

   // a new edge overwrites whatever was pending
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         remain_r  <= 5'h00;
         target_r  <= 1'b0;
         pending_r <= 1'b0;
      end else if (rise_p || fall_p) begin
         remain_r  <= load_steps;
         target_r  <= rise_p;
         pending_r <= (load_steps != 5'h00);
      end else if (pending_r && tick) begin
         remain_r  <= remain_r - 5'h01;
         pending_r <= (remain_r != 5'h01);
      end
   end

   // code zero switches on the cycle after the edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         active_r <= 1'b0;
      end else if (rise_p || fall_p) begin
         if (load_steps == 5'h00) begin
            active_r <= rise_p;
         end
      end else if (pending_r && tick && remain_r == 5'h01) begin
         active_r <= target_r;
      end
   end

endmodule

//--- tb/host_enable_model.sv
// host side of the enable pin: follows a requested level after a lag
// assumes requests change away from the falling clock edge
module host_enable_model (
   input  wire logic clk,
   input  wire logic want_high,
   input  wire logic slow,
   output logic      enable_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned wait_r;
   initial begin
      enable_pin = 1'b0;
      wait_r = 0;
   end
   // a slow host lets the request sit several cycles before moving the pin
   always @(negedge clk) begin
      if (want_high == enable_pin) begin
         wait_r <= 0;
      end else if (wait_r >= (slow ? 5 : 1)) begin
         enable_pin <= want_high;
         wait_r <= 0;
      end else begin
         wait_r <= wait_r + 1;
      end
   end
endmodule

//--- tb/aux_output_sequencer_config_bench.sv
// self-checking bench for the auxiliary output sequencer and its registers
// assumes the design package is compiled first; delay step shortened to 10 cycles
module aux_output_sequencer_config_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import aux_seq_pkg::*;
   localparam int STEP = 10;
   localparam int LAT = 4; // two sync flops, channel active flop and output flop
   logic      clk, reset, want_high, slow, reg_wr, reg_rd, shared_pin_in, enable_pin;
   reg_addr_t reg_addr;
   reg_data_t reg_wdata, reg_rdata_r;
   logic      aux_a_out_r, aux_a_oe_n_r, aux_b_out_r, aux_b_oe_n_r, ext_clock_input_r;
   logic      shared_pin_pulldown_r, enable_pin_pulldown_r;
   logic      thermal_warning_threshold_r, spread_clock_enable_r;
   int        n_errors, n_checks, ta, tb_n, i;
   reg_data_t ctrl_tab [5] = '{8'h11, 8'h00, 8'h55, 8'h44, 8'h33};
   logic [3:0] pin_tab [5] = '{4'b1010, 4'b0000, 4'b0101, 4'b0000, 4'b0000};
   reg_data_t cfg_tab  [4] = '{8'h0f, 8'h00, 8'h0a, 8'h85};

   host_enable_model u_host (.clk(clk), .want_high(want_high), .slow(slow),
                             .enable_pin(enable_pin));

   aux_output_sequencer_config #(.STEP_CYCLES(STEP)) u_dut (
      .clk(clk), .reset(reset), .enable_pin(enable_pin), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .aux_a_out_r(aux_a_out_r), .aux_a_oe_n_r(aux_a_oe_n_r), .shared_pin_in(shared_pin_in),
      .aux_b_out_r(aux_b_out_r), .aux_b_oe_n_r(aux_b_oe_n_r),
      .ext_clock_input_r(ext_clock_input_r), .shared_pin_pulldown_r(shared_pin_pulldown_r),
      .enable_pin_pulldown_r(enable_pin_pulldown_r),
      .thermal_warning_threshold_r(thermal_warning_threshold_r),
      .spread_clock_enable_r(spread_clock_enable_r));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input reg_data_t got, input reg_data_t exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // a cycle of slack covers the synchroniser's phase against the pin change
   task automatic near(input int got, input int exp, input string what);
      n_checks++;
      if (got < exp - 1 || got > exp + 1) begin
         n_errors++;
         $display("[FAIL] %0t %s took %0d cycles, expected %0d", $time, what, got, exp);
      end
   endtask

   task automatic wr(input reg_addr_t a, input reg_data_t d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd_chk(input reg_addr_t a, input reg_data_t exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      check(reg_rdata_r, exp, "read data");
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // moves the pin, then counts cycles until each output reaches the new level
   task automatic measure(input logic lvl, input int ea, input int eb);
      @(posedge clk);
      want_high = lvl;
      for (i = 0; i < 50 && enable_pin !== lvl; i++) @(posedge clk);
      ta = -1;
      tb_n = -1;
      for (i = 1; i <= 400 && (ta < 0 || tb_n < 0); i++) begin
         @(negedge clk);
         if (ta < 0 && aux_a_out_r === lvl) ta = i;
         if (tb_n < 0 && aux_b_out_r === lvl) tb_n = i;
      end
      if (enable_pin !== lvl || ta < 0 || tb_n < 0) begin
         n_errors++;
         $display("[FAIL] %0t output never followed the enable pin", $time);
         print_verdict();
      end
      near(ta, ea, "output a");
      near(tb_n, eb, "output b");
      check({6'h00, aux_a_oe_n_r, aux_b_oe_n_r}, 8'h00, "push-pull enables");
   endtask

   initial begin
      n_errors = 0;
      n_checks = 0;
      reset = 1'b1;
      want_high = 1'b0;
      slow = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      shared_pin_in = 1'b0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;

      wr(8'h14, 8'hff);
      rd_chk(ADDR_AUX_A_DELAY, 8'h07);
      rd_chk(ADDR_AUX_B_DELAY, 8'h22);
      rd_chk(ADDR_AUX_CTRL, 8'h77);
      rd_chk(ADDR_DEV_CONFIG, 8'h06);
      rd_chk(8'h14, 8'h00);
      check({4'h0, shared_pin_pulldown_r, enable_pin_pulldown_r, thermal_warning_threshold_r,
             spread_clock_enable_r}, 8'h06, "config pins at reset");
      wr(ADDR_AUX_CTRL, 8'hff);
      rd_chk(ADDR_AUX_CTRL, 8'h77);
      $display("test registers done");

      for (int k = 0; k < 5; k++) begin
         wr(ADDR_AUX_CTRL, ctrl_tab[k]);
         idle(3);
         check({4'h0, aux_a_out_r, aux_a_oe_n_r, aux_b_out_r, aux_b_oe_n_r},
               {4'h0, pin_tab[k]}, "static drive");
      end
      $display("test static drive done");

      // gated push-pull: a rises after 3 steps, falls at once; b 1 step up, 2 down
      wr(ADDR_AUX_A_DELAY, 8'h03);
      wr(ADDR_AUX_B_DELAY, 8'h21);
      measure(1'b1, LAT + 3 * STEP, LAT + STEP);
      measure(1'b0, LAT, LAT + 2 * STEP);
      wr(ADDR_DEV_CONFIG, 8'h66);
      slow = 1'b1;
      measure(1'b1, LAT + 6 * STEP, LAT + 2 * STEP);
      measure(1'b0, LAT, LAT + 4 * STEP);
      slow = 1'b0;
      wr(ADDR_DEV_CONFIG, 8'h06);
      $display("test sequencing done");

      // a falling edge inside the rise delay must cancel the pending rise
      @(posedge clk);
      want_high = 1'b1;
      idle(15);
      want_high = 1'b0;
      ta = 0;
      for (int k = 0; k < 60; k++) begin
         @(negedge clk);
         if (aux_a_out_r !== 1'b0) ta = 1;
      end
      check(8'(ta), 8'h00, "cancelled rise");
      $display("test cancel done");

      wr(ADDR_AUX_CTRL, 8'h11);
      wr(ADDR_DEV_CONFIG, 8'h16);
      shared_pin_in = 1'b1;
      idle(5);
      check({6'h00, aux_b_oe_n_r, ext_clock_input_r}, 8'h03, "clock input high");
      shared_pin_in = 1'b0;
      idle(5);
      check({6'h00, aux_b_oe_n_r, ext_clock_input_r}, 8'h02, "clock input low");
      shared_pin_in = 1'b1;
      wr(ADDR_DEV_CONFIG, 8'h06);
      idle(5);
      check({6'h00, aux_b_oe_n_r, ext_clock_input_r, aux_b_out_r}, 8'h01, "pin as output");
      $display("test pin function done");

      for (int k = 0; k < 4; k++) begin
         wr(ADDR_DEV_CONFIG, cfg_tab[k]);
         idle(2);
         check({4'h0, shared_pin_pulldown_r, enable_pin_pulldown_r, thermal_warning_threshold_r,
                spread_clock_enable_r}, {4'h0, cfg_tab[k][3:0]}, "config pins");
         rd_chk(ADDR_DEV_CONFIG, cfg_tab[k]);
      end
      $display("test config done");
      print_verdict();
   end
endmodule
